/* File: core/temp_sensor_pkg.sv */
// Constants shared by the temperature sensor register core.
// Assumes a single 20 MHz system clock; no other dependencies.
package temp_sensor_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   // System clock rate in hertz.
   localparam int CLK_HZ = 20_000_000;
   // Time between periodic conversions, in milliseconds.
   localparam int CONV_PERIOD_MS = 80;
   // Conversion period in clock cycles, derived from the rate.
   localparam int CONV_PERIOD_CYCLES = CONV_PERIOD_MS * (CLK_HZ / 1000);

   // ==========================================================
   // Pointer select codes (low three bits of the pointer)
   // ==========================================================
   localparam logic [2:0] SEL_RESULT = 3'h0;
   localparam logic [2:0] SEL_CONFIG = 3'h1;
   localparam logic [2:0] SEL_HYST = 3'h2;
   localparam logic [2:0] SEL_LIMIT = 3'h3;
   localparam logic [2:0] SEL_TRIGGER = 3'h4;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   // Codes are 12 bits, the register image shifts them up by four.
   localparam logic [11:0] RESULT_RESET = 12'h000;
   localparam logic [11:0] HYST_RESET = 12'h4b0;
   localparam logic [11:0] LIMIT_RESET = 12'h500;
   localparam logic [3:0] CODE_PAD = 4'h0;

   // ==========================================================
   // Configuration field positions
   // ==========================================================
   localparam int CFG_SHUTDOWN = 0;
   localparam int CFG_INTR_MODE = 1;
   localparam int CFG_POLARITY = 2;
   localparam int CFG_QUEUE_LO = 3;
   localparam int CFG_QUEUE_HI = 4;
   localparam int CFG_ONE_SHOT = 5;

   // ==========================================================
   // Fault queue depths selected by the two queue bits
   // ==========================================================
   localparam logic [2:0] QUEUE_DEPTH_00 = 3'h1;
   localparam logic [2:0] QUEUE_DEPTH_01 = 3'h2;
   localparam logic [2:0] QUEUE_DEPTH_10 = 3'h4;
   localparam logic [2:0] QUEUE_DEPTH_11 = 3'h6;

   // Conversion sequencer states, Gray coded in listed order; idle to single changes both bits.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PERIODIC = 2'b01,
      ST_SINGLE = 2'b11
   } conv_state_e;

endpackage

/* File: core/pin_synchronizer.sv */
// Two-stage synchroniser for a group of pin-level inputs.
// Assumes each bit is a level from outside the ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module pin_synchronizer #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset,
   // Asynchronous levels in, synchronised levels out.
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // ==========================================================
   // State
   // ==========================================================
   // The first stage is read only by the second stage.
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_s;

   sync_s s;
   sync_s next_s;

   // Refuse a zero-width group at elaboration.
   if (WIDTH < 1) begin : g_bad_width
      $error("pin_synchronizer needs WIDTH of at least one");
   end

   // Shift the levels through both stages.
   always_comb begin
      next_s = s;
      next_s.stage1 = async_in;
      next_s.stage2 = s.stage1;
   end

   // Register the state; reset clears both stages.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.stage2;

endmodule
`default_nettype wire

/* File: core/temp_sensor_core.sv */
// Register core of a serially programmed temperature sensor.
// Assumes a serial engine presents register accesses as levels that
// are stable around each rising edge of its own link clock, and an
// analog model returns one 12-bit code per requested conversion.
//
// Behaviour
// R1: Convert every 80 ms, store, compare.
// R2: Reads during conversion return old result.
// R3: Shutdown stops conversions, keeps last result.
// R4: Configuration bit 0 selects shutdown.
// R5: Trigger write in shutdown runs one conversion.
// R6: Comparator mode clears below hysteresis limit.
// R7: Interrupt mode clears after read and below.
// R8: Output polarity is configurable.
// R9: Temperature registers hold left-justified 12-bit codes.
// R10: Low four bits of temperature registers read zero.
// R11: Master reads two bytes for full code.
// R12: Code counts sixteenths of a degree, signed.
// R13: One-shot bit forces shutdown immediately.
// R14: Trigger write data is discarded.
// R15: Bits 3 and 4 set fault queue depth.
// R16: Pointer, config, trigger 8-bit; others 16.
// R17: Result read only, others read and write.
// R18: Pointer low bits select; resets to zero.
// R19: Select codes map result through trigger.
// R20: Queue codes mean one, two, four, six.
// R21: Polarity bit zero means active low.
// R22: Bit 1 selects comparator or interrupt.
// R23: Bit 0 high powers down the converter.
// R24: Any completed read acknowledges interrupt.
// R25: Unused select codes ignore writes, read zero.
// R26: Non-fault result clears the fault counter.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_core
   import temp_sensor_pkg::*;
#(
   parameter int PERIOD_CYCLES = CONV_PERIOD_CYCLES
) (
   // System clock and reset.
   input wire logic ref_clk,
   input wire logic reset,
   // Register access from the serial engine, on its link clock.
   input wire logic link_clk,
   input wire logic acc_ptr_wr,
   input wire logic acc_reg_wr,
   input wire logic acc_reg_rd,
   input wire logic [15:0] acc_wdata,
   output logic [15:0] rd_data,
   // Converter model handshake.
   output logic conv_start,
   input wire logic conv_done,
   input wire logic [11:0] conv_code,
   // Open-drain over-temperature pin.
   input wire logic over_temp_output_in,
   output logic over_temp_output_out,
   output logic over_temp_output_oe
);

   // ==========================================================
   // Parameter checks
   // ==========================================================
   // The period counter is 24 bits wide.
   if (PERIOD_CYCLES < 2 || PERIOD_CYCLES > 16777215) begin : g_bad
      $error("temp_sensor_core PERIOD_CYCLES out of range");
   end

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      conv_state_e state;       // Conversion sequencer.
      logic [23:0] period_cnt;  // Cycles to next periodic start.
      logic link_prev;          // Last synchronised link clock.
      logic [7:0] pointer;      // Register select.
      logic [7:0] config_reg;   // Mode bits.
      logic [11:0] result;      // Last stored code.
      logic [11:0] hyst;        // Hysteresis limit code.
      logic [11:0] limit;       // Over-temperature limit code.
      logic [2:0] fault_cnt;    // Consecutive faults seen.
      logic alert;              // Over-temperature asserted.
      logic below_hyst;         // Last result under hysteresis.
      logic read_seen;          // Read acknowledge while alert.
      logic [15:0] rd_data;     // Read return word.
      logic conv_start;         // One-cycle converter request.
      logic pin_oe;             // Pin pulled low when set.
      logic pin_out;            // Pin drive level, always low.
   } core_s;

   core_s s;
   core_s next_s;

   // Synchronised access levels: clock, three strobes, data.
   logic [19:0] acc_sync;
   logic link_rise;
   logic ptr_ev;
   logic wr_ev;
   logic rd_ev;
   logic [2:0] sel;
   logic [15:0] wdata;
   logic shut;
   logic done;
   logic fault;
   logic below;
   logic [2:0] cnt_inc;
   logic [2:0] depth;
   logic qualified;
   logic trigger_ev;
   logic periodic_ev;
   logic [15:0] read_word;

   // The pin readback has no use inside the core.
   logic unused_pin;
   assign unused_pin = over_temp_output_in;

   // ==========================================================
   // Link-side inputs
   // ==========================================================
   // Everything from the serial engine crosses two flip-flops. The
   // strobes and data are sampled at the link clock's rising edge,
   // which the synchronised clock shows about two cycles late; the
   // engine must hold them for that long past its edge.
   pin_synchronizer #(
      .WIDTH(20)
   ) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .async_in({link_clk, acc_ptr_wr, acc_reg_wr, acc_reg_rd,
                 acc_wdata}),
      .sync_out(acc_sync)
   );

   assign link_rise = acc_sync[19] & ~s.link_prev;
   assign ptr_ev = link_rise & acc_sync[18];
   assign wr_ev = link_rise & acc_sync[17] & ~acc_sync[18];
   assign rd_ev = link_rise & acc_sync[16] & ~acc_sync[18]
                  & ~acc_sync[17];
   assign wdata = acc_sync[15:0];
   assign sel = s.pointer[2:0]; // R18

   // ==========================================================
   // Mode decode and comparison
   // ==========================================================
   // Either the shutdown bit or the one-shot bit holds the core idle.
   assign shut = s.config_reg[CFG_SHUTDOWN]
                 | s.config_reg[CFG_ONE_SHOT]; // R4 R13 R23

   // A code that reaches the limit counts as a fault.
   assign done = conv_done & (s.state != ST_IDLE);
   assign fault = $signed(conv_code) >= $signed(s.limit); // R12
   assign below = $signed(conv_code) < $signed(s.hyst); // R12

   // Count saturates at the deepest queue setting.
   assign cnt_inc = (s.fault_cnt >= QUEUE_DEPTH_11) ? QUEUE_DEPTH_11
                    : s.fault_cnt + 3'h1;

   // Decode the queue depth field.
   always_comb begin
      case (s.config_reg[CFG_QUEUE_HI:CFG_QUEUE_LO]) // R15
         2'b00: depth = QUEUE_DEPTH_00; // R20
         2'b01: depth = QUEUE_DEPTH_01; // R20
         2'b10: depth = QUEUE_DEPTH_10; // R20
         default: depth = QUEUE_DEPTH_11; // R20
      endcase
   end

   assign qualified = done & fault & (cnt_inc >= depth); // R15

   // A trigger write only starts anything while shut down.
   assign trigger_ev = wr_ev & (sel == SEL_TRIGGER) & shut
                       & (s.state == ST_IDLE); // R5
   assign periodic_ev = (s.period_cnt == 24'h000000) & ~shut
                        & (s.state == ST_IDLE); // R1 R3

   // Read multiplexer; temperature registers pad the low nibble.
   always_comb begin
      case (sel) // R19
         SEL_RESULT: read_word = {s.result, CODE_PAD}; // R9 R10
         SEL_CONFIG: read_word = {8'h00, s.config_reg}; // R16
         SEL_HYST: read_word = {s.hyst, CODE_PAD}; // R10
         SEL_LIMIT: read_word = {s.limit, CODE_PAD}; // R10
         default: read_word = 16'h0000; // R25
      endcase
   end

   // ==========================================================
   // Next-state logic
   // ==========================================================
   always_comb begin
      next_s = s;
      next_s.conv_start = 1'b0;
      next_s.link_prev = acc_sync[19];

      // Free-running period counter; starts are taken only in idle.
      if (s.period_cnt == 24'h000000) begin
         next_s.period_cnt = 24'(PERIOD_CYCLES - 1); // R1
      end else begin
         next_s.period_cnt = s.period_cnt - 24'h000001;
      end

      // Register writes; the result register has no write path.
      if (ptr_ev) begin
         next_s.pointer = wdata[7:0]; // R18
      end else if (wr_ev) begin
         case (sel) // R17 R19
            SEL_CONFIG: next_s.config_reg = wdata[7:0];
            SEL_HYST: next_s.hyst = wdata[15:4]; // R9
            SEL_LIMIT: next_s.limit = wdata[15:4]; // R9
            default: next_s = next_s; // R14 R25
         endcase
      end

      // Reads return the stored word and never touch the sequencer.
      if (rd_ev) begin
         next_s.rd_data = read_word; // R2 R11
         if (s.alert) begin
            next_s.read_seen = 1'b1; // R24
         end
      end

      // Conversion sequencer.
      case (s.state)
         ST_IDLE: begin
            if (periodic_ev) begin
               next_s.state = ST_PERIODIC; // R1
               next_s.conv_start = 1'b1;
            end else if (trigger_ev) begin
               next_s.state = ST_SINGLE; // R5
               next_s.conv_start = 1'b1;
            end
         end
         ST_PERIODIC, ST_SINGLE: begin
            // A conversion in flight finishes even if shutdown is set
            // meanwhile; the old result stays readable until then.
            if (conv_done) begin
               next_s.state = ST_IDLE;
               next_s.result = conv_code; // R1 R2
               next_s.below_hyst = below;
               next_s.fault_cnt = fault ? cnt_inc : 3'h0; // R26
            end
         end
         default: next_s.state = ST_IDLE;
      endcase

      // Alert: a qualified fault sets it and wins over any clear.
      if (qualified) begin
         next_s.alert = 1'b1; // R15
         next_s.read_seen = 1'b0;
      end else if (s.alert) begin
         if (s.config_reg[CFG_INTR_MODE]) begin
            if (next_s.read_seen && next_s.below_hyst) begin
               next_s.alert = 1'b0; // R7 R22
               next_s.read_seen = 1'b0;
            end
         end else if (done && below) begin
            next_s.alert = 1'b0; // R6 R22
         end
      end

      // Active low pulls the pin while alert; active high releases it.
      next_s.pin_oe = s.alert ^ s.config_reg[CFG_POLARITY]; // R8 R21
      next_s.pin_out = 1'b0;
   end

   // ==========================================================
   // State register
   // ==========================================================
   // Period counter resets to zero so the first conversion starts
   // right after reset.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         s.state <= ST_IDLE;
         s.period_cnt <= 24'h000000;
         s.link_prev <= 1'b0;
         s.pointer <= POINTER_RESET; // R18
         s.config_reg <= CONFIG_RESET;
         s.result <= RESULT_RESET;
         s.hyst <= HYST_RESET;
         s.limit <= LIMIT_RESET;
         s.fault_cnt <= 3'h0;
         s.alert <= 1'b0;
         s.below_hyst <= 1'b0;
         s.read_seen <= 1'b0;
         s.rd_data <= 16'h0000;
         s.conv_start <= 1'b0;
         s.pin_oe <= 1'b0;
         s.pin_out <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign rd_data = s.rd_data;
   assign conv_start = s.conv_start;
   assign over_temp_output_out = s.pin_out;
   assign over_temp_output_oe = s.pin_oe;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   chk_periodic_start: assert property ( // R1
      periodic_ev |=> conv_start && s.state == ST_PERIODIC)
      else $error("periodic conversion did not start");

   chk_result_hold: assert property ( // R2
      !done |=> $stable(s.result))
      else $error("result changed outside conversion end");

   chk_result_store: assert property ( // R1
      done |=> s.result == $past(conv_code))
      else $error("result not stored at conversion end");

   chk_shutdown_quiet: assert property ( // R3
      shut && !trigger_ev |=> !conv_start)
      else $error("conversion started while shut down");

   chk_trigger_single: assert property ( // R5
      trigger_ev |=> conv_start && s.state == ST_SINGLE)
      else $error("trigger write did not start one conversion");

   chk_low_nibble: assert property ( // R10
      rd_ev && sel != SEL_CONFIG |=> rd_data[3:0] == 4'h0)
      else $error("temperature register low bits not zero");

   chk_unmapped_read: assert property ( // R25
      rd_ev && sel > SEL_TRIGGER |=> rd_data == 16'h0000)
      else $error("unmapped select read not zero");

   chk_pin_level: assert property ( // R8
      over_temp_output_oe == $past(s.alert ^ s.config_reg[CFG_POLARITY]))
      else $error("pin enable does not follow alert and polarity");

   chk_comp_clear: assert property ( // R6
      done && below && !qualified && !s.config_reg[CFG_INTR_MODE]
      |=> !s.alert)
      else $error("comparator alert did not clear");

   chk_intr_hold: assert property ( // R7
      s.alert && s.config_reg[CFG_INTR_MODE] && !rd_ev && !s.read_seen
      |=> s.alert)
      else $error("interrupt alert cleared without a read");

   chk_fault_reset: assert property ( // R26
      done && !fault |=> s.fault_cnt == 3'h0)
      else $error("fault counter not cleared by a good result");

   cov_periodic: cover property (periodic_ev ##[1:300] done);
   cov_single: cover property (trigger_ev ##[1:300] done);
   cov_alert: cover property ($rose(s.alert));
   cov_intr_clear: cover property (
      s.config_reg[CFG_INTR_MODE] && $fell(s.alert));

endmodule
`default_nettype wire

/* File: bench/link_master.sv */
// Stand-in for the serial engine that faces the register core.
// Assumes the bench calls access() just after a ref_clk rising edge.
`timescale 1ns/1ps
`default_nettype none
module link_master (
   // Access lines toward the core.
   output logic link_clk,
   output logic acc_ptr_wr,
   output logic acc_reg_wr,
   output logic acc_reg_rd,
   output logic [15:0] acc_wdata,
   // Read word returned by the core.
   input wire logic [15:0] rd_data
);
   // Word fetched by the most recent read access.
   logic [15:0] last_rd;

   // ==========================================================
   // Idle state
   // ==========================================================
   // The link clock stands low between frames.
   initial begin
      link_clk = 1'b0;
      acc_ptr_wr = 1'b0;
      acc_reg_wr = 1'b0;
      acc_reg_rd = 1'b0;
      acc_wdata = 16'hffff;
      last_rd = 16'h0000;
   end

   // One access per link rise: kind 0 pointer, 1 write, 2 read.
   // Lines stay put for eight ref_clk cycles after the rise, so the
   // two-stage sampling in the core always sees settled levels.
   task automatic access(input logic [1:0] kind, input logic [15:0] d);
      acc_ptr_wr = (kind == 2'h0);
      acc_reg_wr = (kind == 2'h1);
      acc_reg_rd = (kind == 2'h2);
      acc_wdata = d;
      #200 link_clk = 1'b1;
      #200 link_clk = 1'b0;
      #200;
      // The whole word is taken, never a single byte.
      last_rd = rd_data;
      acc_ptr_wr = 1'b0;
      acc_reg_wr = 1'b0;
      acc_reg_rd = 1'b0;
      // Released data shows the inverse so a stale value cannot pass.
      acc_wdata = ~d;
      // One ref_clk edge passes before the next access may start.
      #50;
   endtask
endmodule
`default_nettype wire

/* File: bench/temp_sensor_alert_regs_test.sv */
// Self-checking bench for the temperature sensor register core.
// Assumes link_master drives the access side and a converter
// stand-in here answers each conversion start after LAT cycles.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_alert_regs_test import temp_sensor_pkg::*;;
   localparam int PER = 200;
   localparam int LAT = 60;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic link_clk, acc_ptr_wr, acc_reg_wr, acc_reg_rd;
   logic [15:0] acc_wdata, rd_data;
   logic conv_start, conv_done = 1'b0;
   logic [11:0] conv_code = 12'h000;
   logic [11:0] temp_code = 12'h000;
   logic oe, od_out, pin;
   int cyc = 0, cd = -1, n_start = 0, t_start = 0, n_done = 0;
   int n_errors = 0, samples_checked = 0;

   // The alert pin has a pull-up; the core only ever pulls it low.
   assign pin = oe ? od_out : 1'b1;

   temp_sensor_core #(.PERIOD_CYCLES(PER)) dut (
      .ref_clk(ref_clk), .reset(reset), .link_clk(link_clk),
      .acc_ptr_wr(acc_ptr_wr), .acc_reg_wr(acc_reg_wr),
      .acc_reg_rd(acc_reg_rd), .acc_wdata(acc_wdata),
      .rd_data(rd_data), .conv_start(conv_start),
      .conv_done(conv_done), .conv_code(conv_code),
      .over_temp_output_in(pin), .over_temp_output_out(od_out),
      .over_temp_output_oe(oe));
   link_master link (
      .link_clk(link_clk), .acc_ptr_wr(acc_ptr_wr),
      .acc_reg_wr(acc_reg_wr), .acc_reg_rd(acc_reg_rd),
      .acc_wdata(acc_wdata), .rd_data(rd_data));

   always #25 ref_clk = ~ref_clk;

   // ==========================================================
   // Converter stand-in
   // ==========================================================
   // The code line toggles outside the done pulse to expose misuse.
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (conv_start === 1'b1) begin
         n_start = n_start + 1;
         t_start = cyc;
         cd = LAT;
      end
      #1;
      conv_done = (cd == 0);
      conv_code = (cd == 0) ? temp_code : ~conv_code;
      if (cd == 0) n_done = n_done + 1;
      if (cd >= 0) cd = cd - 1;
   end

   // ==========================================================
   // Shared tasks
   // ==========================================================
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Waits for n answered conversions, then lets the pin settle.
   task automatic wait_done(input int n);
      int target;
      target = n_done + n;
      for (int i = 0; i < 2000 && n_done < target; i++) @(posedge ref_clk);
      if (n_done < target) begin
         n_errors++;
         $display("[ERR] conversions expected %0d seen %0d", target, n_done);
         end_of_test();
      end
      idle(4);
   endtask

   task automatic wr(input logic [2:0] sel, input logic [15:0] d);
      link.access(2'h0, {13'h0, sel});
      link.access(2'h1, d);
   endtask

   task automatic rd(input logic [2:0] sel, output logic [15:0] v);
      link.access(2'h0, {13'h0, sel});
      link.access(2'h2, 16'h0000);
      v = link.last_rd;
   endtask

   // Counts hot conversions until the pin is pulled low.
   task automatic count_faults(input logic [2:0] exp_n);
      int n;
      n = 0;
      temp_code = 12'h100;
      while (pin === 1'b1 && n < 8) begin
         wait_done(1);
         n++;
      end
      chk("fault count", {13'h0, exp_n}, n[15:0]);
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_reset();
      logic [15:0] v;
      link.access(2'h2, 16'h0000);
      chk("result, no pointer", 16'h0000, link.last_rd);
      rd(SEL_CONFIG, v);
      chk("config reset", 16'h0000, v);
      rd(SEL_HYST, v);
      chk("hyst reset", 16'h4b00, v);
      rd(SEL_LIMIT, v);
      chk("limit reset", 16'h5000, v);
      rd(3'h5, v);
      chk("unused read", 16'h0000, v);
      chk("pin idle", 16'h0001, {15'h0, pin});
      $display("reset test done");
   endtask

   task automatic t_periodic();
      int t1;
      logic [15:0] v;
      temp_code = 12'he70;
      wait_done(1);
      t1 = t_start;
      wait_done(1);
      chk("period", PER[15:0], 16'(t_start - t1));
      rd(SEL_RESULT, v);
      chk("negative result", 16'he700, v);
      temp_code = 12'h190;
      t1 = n_start;
      for (int i = 0; i < 400 && n_start == t1; i++) idle(1);
      chk("next start", 16'(t1 + 1), 16'(n_start));
      t1 = n_done;
      rd(SEL_RESULT, v);
      chk("read in flight", 16'he700, v);
      wait_done(1);
      chk("conversion kept", 16'(t1 + 1), 16'(n_done));
      rd(SEL_RESULT, v);
      chk("new result", 16'h1900, v);
      $display("periodic test done");
   endtask

   task automatic t_regs();
      logic [15:0] v;
      wr(SEL_CONFIG, 16'h00d8);
      rd(SEL_CONFIG, v);
      chk("config rw", 16'h00d8, v);
      wr(SEL_CONFIG, 16'h0000);
      wr(SEL_HYST, 16'h123f);
      rd(SEL_HYST, v);
      chk("hyst low bits", 16'h1230, v);
      wr(SEL_LIMIT, 16'h456f);
      rd(SEL_LIMIT, v);
      chk("limit low bits", 16'h4560, v);
      wr(SEL_RESULT, 16'habcd);
      rd(SEL_RESULT, v);
      chk("result read only", 16'h1900, v);
      wr(SEL_TRIGGER, 16'h00a5);
      rd(SEL_TRIGGER, v);
      chk("trigger data", 16'h0000, v);
      wr(3'h6, 16'h5555);
      rd(3'h6, v);
      chk("unused write", 16'h0000, v);
      $display("register test done");
   endtask

   task automatic t_queue();
      logic [2:0] depth [4];
      depth = '{3'h1, 3'h2, 3'h4, 3'h6};
      wr(SEL_LIMIT, 16'h1000);
      wr(SEL_HYST, 16'h0f00);
      for (int q = 0; q < 4; q++) begin
         temp_code = 12'h000;
         wr(SEL_CONFIG, {11'h0, q[1:0], 3'h0});
         wait_done(2);
         count_faults(depth[q]);
      end
      temp_code = 12'h000;
      wait_done(2);
      temp_code = 12'h100;
      wait_done(5);
      temp_code = 12'h0f8;
      wait_done(1);
      count_faults(3'h6);
      temp_code = 12'h0f8;
      wait_done(2);
      chk("above hyst", 16'h0000, {15'h0, pin});
      temp_code = 12'h0ef;
      wait_done(1);
      chk("below hyst", 16'h0001, {15'h0, pin});
      $display("queue test done");
   endtask

   task automatic t_intr();
      logic [15:0] v;
      wr(SEL_CONFIG, 16'h0002);
      wait_done(1);
      temp_code = 12'h100;
      wait_done(1);
      chk("intr set", 16'h0000, {15'h0, pin});
      temp_code = 12'h000;
      wait_done(2);
      chk("no read yet", 16'h0000, {15'h0, pin});
      rd(SEL_CONFIG, v);
      chk("read clears", 16'h0001, {15'h0, pin});
      temp_code = 12'h100;
      wait_done(1);
      temp_code = 12'h000;
      rd(SEL_HYST, v);
      chk("still hot", 16'h0000, {15'h0, pin});
      wait_done(1);
      chk("cool clears", 16'h0001, {15'h0, pin});
      $display("interrupt test done");
   endtask

   task automatic t_polarity();
      wr(SEL_CONFIG, 16'h0004);
      chk("high idle", 16'h0000, {15'h0, pin});
      temp_code = 12'h100;
      wait_done(1);
      chk("high alert", 16'h0001, {15'h0, pin});
      temp_code = 12'h000;
      wr(SEL_CONFIG, 16'h0000);
      wait_done(1);
      $display("polarity test done");
   endtask

   task automatic t_shut();
      int s;
      logic [15:0] v;
      temp_code = 12'h0a5;
      wait_done(1);
      wr(SEL_CONFIG, 16'h0001);
      idle(100);
      s = n_start;
      temp_code = 12'h100;
      idle(3 * PER);
      chk("shut starts", 16'(s), 16'(n_start));
      rd(SEL_RESULT, v);
      chk("held result", 16'h0a50, v);
      wr(SEL_TRIGGER, 16'h00ff);
      wait_done(1);
      rd(SEL_RESULT, v);
      chk("shot result", 16'h1000, v);
      chk("shot alert", 16'h0000, {15'h0, pin});
      idle(3 * PER);
      chk("one start", 16'(s + 1), 16'(n_start));
      wr(SEL_CONFIG, 16'h0020);
      s = n_start;
      temp_code = 12'h000;
      idle(3 * PER);
      chk("oneshot starts", 16'(s), 16'(n_start));
      wr(SEL_TRIGGER, 16'h0000);
      wait_done(1);
      idle(3 * PER);
      chk("oneshot one", 16'(s + 1), 16'(n_start));
      chk("oneshot clear", 16'h0001, {15'h0, pin});
      wr(SEL_CONFIG, 16'h0000);
      wait_done(1);
      $display("shutdown test done");
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      idle(5);
      reset = 1'b0;
      idle(2);
      t_reset();
      t_periodic();
      t_regs();
      t_queue();
      t_intr();
      t_polarity();
      t_shut();
      end_of_test();
   end
endmodule
`default_nettype wire
